// [pin_share_pkg.sv]
// Constants and carrier types for the port pin-sharing block
// Summary of operation
// - Ports one to three each have eight bidirectional pins under software control.
// - Every pin except port four bit 3 picks port use or its special function on its own.
// - Port one bits 0-3 carry capture/compare 0-3; bit 4 timer A clock.
// - Port one bit 5 timer A direction, bit 6 timer B clock, bit 7 direction.
// - Port two bits 0-4: serial tx, serial rx, irq 0, bus request, irq 1.
// - Port two bit 5 hold request, bit 6 hold acknowledge, bit 7 clock output.
// - Port three bits 0-5 carry the six active-low chip selects.
// - Port three bit 6 carries external irq 2, bit 7 external irq 3.
// - Port four is a four-bit bidirectional high-drive port.
// - Port four bits 0-2 carry pulse-width outputs 0-2.
// - Port four bit 3 has no special function; always a plain port pin.
// - Isolation input is sampled at reset release and held; high means isolated.
// - Isolation floats every pin except ready, reset, isolation and nonmaskable inputs.
// - Isolation ends only when reset is driven low again.
// - With bus-hold enabled, port two bits 5-6 are hold pins; config changes ignored.
package pin_share_pkg;
	localparam int P8_W = 8;
	localparam int P4_W = 4;
	localparam logic [7:0] P2_SF_DRIVE = 8'hc9;
	localparam logic [7:0] P3_SF_DRIVE = 8'h3f;
	localparam logic [3:0] P4_SF_DRIVE = 4'h7;
	localparam logic [3:0] P4_SF_AVAIL = 4'h7;
	localparam int P2_HOLD_LO = 5;
	localparam int P2_HOLD_HI = 6;
	localparam logic ISO_RESET = 1'b0;

	typedef struct packed {
		logic [P8_W-1:0] data;
		logic [P8_W-1:0] dir;
		logic [P8_W-1:0] sel;
	} portCfg_t;

	typedef struct packed {
		logic [P4_W-1:0] data;
		logic [P4_W-1:0] dir;
		logic [P4_W-1:0] sel;
	} portCfg4_t;

	typedef struct packed {
		logic [P8_W-1:0] portOnePins;
		logic [P8_W-1:0] portTwoPins;
		logic [P8_W-1:0] portThreePins;
		logic [P4_W-1:0] portFourPins;
	} padBus_t;

	typedef struct packed {
		logic [3:0] captureCompareOut;
		logic [3:0] captureCompareOe;
		logic serialTx;
		logic busRequestN;
		logic holdAcknowledgeN;
		logic clockOutput;
		logic [5:0] chipSelectN;
		logic [2:0] pulseWidthOut;
	} sfOut_t;

	typedef struct packed {
		logic [3:0] captureCompareIn;
		logic timerAClockIn;
		logic timerADirectionIn;
		logic timerBClockIn;
		logic timerBDirectionIn;
		logic serialRx;
		logic [3:0] extIrq;
		logic holdRequestN;
	} sfIn_t;

	typedef struct packed {
		logic isolated;
		logic releaseSeen;
		logic [1:0] holdSel;
		logic [1:0] holdDir;
		logic [1:0] holdData;
		padBus_t padOut;
		padBus_t padOe;
		padBus_t portRead;
		sfIn_t sfIn;
	} state_t;
endpackage

// [port_pin_sharing_and_isolation.sv]
// Pin multiplexer for ports one to four with isolation mode
module port_pin_sharing_and_isolation
	import pin_share_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic isolationModeInput,
	input wire logic busHoldProtocolEnable,
	input wire portCfg_t cfgOne,
	input wire portCfg_t cfgTwo,
	input wire portCfg_t cfgThree,
	input wire portCfg4_t cfgFour,
	input wire sfOut_t sfOut,
	input wire padBus_t padIn,
	output padBus_t padOut,
	output padBus_t padOe,
	output padBus_t portRead,
	output sfIn_t sfIn
);
	state_t st_r;
	state_t st_nxt;
	portCfg_t effTwo;
	logic [7:0] sf1o;
	logic [7:0] sf1e;
	logic [7:0] sf2o;
	logic [7:0] sf3o;
	logic [3:0] sf4o;
	logic [3:0] sel4;

	always_comb
	begin
		st_nxt = st_r;
		// First enabled cycle after release catches the isolation strap
		if (!st_r.releaseSeen)
		begin
			st_nxt.isolated = isolationModeInput;
			st_nxt.releaseSeen = 1'b1;
		end
		// Hold pins keep their last configuration while the protocol owns them
		if (!busHoldProtocolEnable)
		begin
			st_nxt.holdSel = cfgTwo.sel[P2_HOLD_HI:P2_HOLD_LO];
			st_nxt.holdDir = cfgTwo.dir[P2_HOLD_HI:P2_HOLD_LO];
			st_nxt.holdData = cfgTwo.data[P2_HOLD_HI:P2_HOLD_LO];
		end
		effTwo = cfgTwo;
		effTwo.sel[P2_HOLD_HI:P2_HOLD_LO] = busHoldProtocolEnable ? 2'b11 : st_nxt.holdSel;
		effTwo.dir[P2_HOLD_HI:P2_HOLD_LO] = st_nxt.holdDir;
		effTwo.data[P2_HOLD_HI:P2_HOLD_LO] = st_nxt.holdData;

		sf1o = {4'h0, sfOut.captureCompareOut};
		sf1e = {4'h0, sfOut.captureCompareOe};
		sf2o = {sfOut.clockOutput, sfOut.holdAcknowledgeN, 2'b00, sfOut.busRequestN,
			2'b00, sfOut.serialTx};
		sf3o = {2'b00, sfOut.chipSelectN};
		sf4o = {1'b0, sfOut.pulseWidthOut};
		sel4 = cfgFour.sel & P4_SF_AVAIL;

		// Per-pin selection between port and special function
		st_nxt.padOut.portOnePins = (cfgOne.sel & sf1o) | (~cfgOne.sel & cfgOne.data);
		st_nxt.padOe.portOnePins = (cfgOne.sel & sf1e) | (~cfgOne.sel & cfgOne.dir);
		st_nxt.padOut.portTwoPins = (effTwo.sel & sf2o) | (~effTwo.sel & effTwo.data);
		st_nxt.padOe.portTwoPins = (effTwo.sel & P2_SF_DRIVE) | (~effTwo.sel & effTwo.dir);
		st_nxt.padOut.portThreePins = (cfgThree.sel & sf3o) | (~cfgThree.sel & cfgThree.data);
		st_nxt.padOe.portThreePins = (cfgThree.sel & P3_SF_DRIVE) | (~cfgThree.sel & cfgThree.dir);
		st_nxt.padOut.portFourPins = (sel4 & sf4o) | (~sel4 & cfgFour.data);
		st_nxt.padOe.portFourPins = (sel4 & P4_SF_DRIVE) | (~sel4 & cfgFour.dir);
		if (st_nxt.isolated)
			st_nxt.padOe = '0;

		// Pad input reaches both the port and the peripherals
		st_nxt.portRead = padIn;
		st_nxt.sfIn.captureCompareIn = padIn.portOnePins[3:0];
		st_nxt.sfIn.timerAClockIn = padIn.portOnePins[4];
		st_nxt.sfIn.timerADirectionIn = padIn.portOnePins[5];
		st_nxt.sfIn.timerBClockIn = padIn.portOnePins[6];
		st_nxt.sfIn.timerBDirectionIn = padIn.portOnePins[7];
		st_nxt.sfIn.serialRx = padIn.portTwoPins[1];
		st_nxt.sfIn.extIrq = {padIn.portThreePins[7:6], padIn.portTwoPins[4],
			padIn.portTwoPins[2]};
		st_nxt.sfIn.holdRequestN = padIn.portTwoPins[5];

		if (!clkEn)
			st_nxt = st_r;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			st_r <= '0;
			st_r.isolated <= ISO_RESET;
		end
		else
			st_r <= st_nxt;
	end

	assign padOut = st_r.padOut;
	assign padOe = st_r.padOe;
	assign portRead = st_r.portRead;
	assign sfIn = st_r.sfIn;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence seq_release;
		!$past(reset_n) && clkEn;
	endsequence

	sequence seq_running;
		$past(reset_n) && $past(st_r.releaseSeen) && clkEn && !st_r.isolated;
	endsequence

	a_iso_capture: assert property (seq_release |=> st_r.isolated == $past(isolationModeInput))
		else $error("isolation strap not captured at release");

	a_iso_sticky: assert property (st_r.releaseSeen |=> $stable(st_r.isolated))
		else $error("isolation changed without reset");

	a_iso_floats: assert property (st_r.isolated |-> padOe == '0)
		else $error("pad driven while isolated");

	a_port_route: assert property (seq_running ##0 !cfgOne.sel[0] |=>
		padOut.portOnePins[0] == $past(cfgOne.data[0]) &&
		padOe.portOnePins[0] == $past(cfgOne.dir[0]))
		else $error("port data not routed to pin");

	a_capcmp_route: assert property (seq_running ##0 cfgOne.sel[2] |=>
		padOut.portOnePins[2] == $past(sfOut.captureCompareOut[2]) &&
		padOe.portOnePins[2] == $past(sfOut.captureCompareOe[2]))
		else $error("capture/compare not routed");

	a_chip_select: assert property (seq_running ##0 cfgThree.sel[4] |=>
		padOut.portThreePins[4] == $past(sfOut.chipSelectN[4]) && padOe.portThreePins[4])
		else $error("chip select not routed");

	a_port4_plain: assert property (seq_running ##0 cfgFour.sel[3] |=>
		padOut.portFourPins[3] == $past(cfgFour.data[3]) &&
		padOe.portFourPins[3] == $past(cfgFour.dir[3]))
		else $error("port four bit 3 took a special function");

	a_hold_lock: assert property (seq_running ##0 busHoldProtocolEnable |=>
		!padOe.portTwoPins[5] && padOe.portTwoPins[6] &&
		padOut.portTwoPins[6] == $past(sfOut.holdAcknowledgeN))
		else $error("hold pins not owned by protocol");

	a_hold_frozen: assert property (busHoldProtocolEnable && clkEn |=> $stable(st_r.holdSel))
		else $error("hold pin configuration changed while locked");

	a_irq_fanin: assert property (clkEn |=> sfIn.extIrq[3] == $past(padIn.portThreePins[7]) &&
		portRead.portThreePins[7] == $past(padIn.portThreePins[7]))
		else $error("pad input not fanned out");

	// A low enable with reset released must leave every output untouched
	sequence seq_frozen;
		reset_n && !clkEn;
	endsequence

	// Input-only special functions must leave their pads floated
	a_timer_clk_float: assert property (seq_running ##0 cfgOne.sel[4] |=>
		!padOe.portOnePins[4])
		else $error("timer A clock pin driven");

	a_timer_dir_float: assert property (seq_running ##0 cfgOne.sel[5] |=>
		!padOe.portOnePins[5])
		else $error("timer A direction pin driven");

	a_timer_b_float: assert property (seq_running ##0 cfgOne.sel[6] |=>
		!padOe.portOnePins[6])
		else $error("timer B clock pin driven");

	a_serial_rx: assert property (seq_running ##0 cfgTwo.sel[1] |=>
		!padOe.portTwoPins[1])
		else $error("serial receive pin driven");

	a_irq_low_float: assert property (seq_running ##0 cfgTwo.sel[2] && cfgTwo.sel[4] |=>
		!padOe.portTwoPins[2] && !padOe.portTwoPins[4])
		else $error("interrupt pin on port two driven");

	a_irq_high_float: assert property (seq_running ##0 cfgThree.sel[6] && cfgThree.sel[7] |=>
		!padOe.portThreePins[6] && !padOe.portThreePins[7])
		else $error("interrupt pin on port three driven");

	// Output special functions drive their pads with the peripheral's level
	a_serial_tx: assert property (seq_running ##0 cfgTwo.sel[0] |=>
		padOut.portTwoPins[0] == $past(sfOut.serialTx) && padOe.portTwoPins[0])
		else $error("serial transmit not routed");

	a_bus_request: assert property (seq_running ##0 cfgTwo.sel[3] |=>
		padOut.portTwoPins[3] == $past(sfOut.busRequestN) && padOe.portTwoPins[3])
		else $error("bus request not routed");

	a_clock_out: assert property (seq_running ##0 cfgTwo.sel[7] |=>
		padOut.portTwoPins[7] == $past(sfOut.clockOutput) && padOe.portTwoPins[7])
		else $error("clock output not routed");

	a_pwm_route: assert property (seq_running ##0 cfgFour.sel[1] |=>
		padOut.portFourPins[1] == $past(sfOut.pulseWidthOut[1]) && padOe.portFourPins[1])
		else $error("pulse-width output one not routed");

	a_pwm_two: assert property (seq_running ##0 cfgFour.sel[2] |=>
		padOut.portFourPins[2] == $past(sfOut.pulseWidthOut[2]) && padOe.portFourPins[2])
		else $error("pulse-width output two not routed");

	// Plain port use on the other ports
	a_port2_plain: assert property (seq_running ##0 !cfgTwo.sel[0] |=>
		padOut.portTwoPins[0] == $past(cfgTwo.data[0]) &&
		padOe.portTwoPins[0] == $past(cfgTwo.dir[0]))
		else $error("port two data not routed");

	a_port3_plain: assert property (seq_running ##0 !cfgThree.sel[7] |=>
		padOut.portThreePins[7] == $past(cfgThree.data[7]) &&
		padOe.portThreePins[7] == $past(cfgThree.dir[7]))
		else $error("port three data not routed");

	// Peripheral inputs see the pad one cycle later
	a_rx_fanin: assert property (clkEn |=>
		sfIn.serialRx == $past(padIn.portTwoPins[1]) &&
		sfIn.holdRequestN == $past(padIn.portTwoPins[5]))
		else $error("serial or hold input not fanned out");

	a_timer_fanin: assert property (clkEn |=>
		sfIn.captureCompareIn == $past(padIn.portOnePins[3:0]) &&
		sfIn.timerBDirectionIn == $past(padIn.portOnePins[7]))
		else $error("timer input not fanned out");

	a_state_frozen: assert property (seq_frozen |=>
		$stable(padOut) && $stable(padOe) && $stable(portRead) && $stable(sfIn))
		else $error("outputs moved while clock enable low");
endmodule

// [pad_board_model.sv]
// Board model: each pad follows the chip where it drives, else the board's level
module pad_board_model
	import pin_share_pkg::*;
(
	input wire padBus_t padOut,
	input wire padBus_t padOe,
	input wire padBus_t boardDrive,
	output padBus_t padIn
);
	// Released pins show the board level, never the chip's last value
	assign padIn = (padOut & padOe) | (boardDrive & ~padOe);
endmodule

// [port_pin_sharing_and_isolation_tb.sv]
// Self-checking bench for the port pin-sharing and isolation block
module port_pin_sharing_and_isolation_tb
	import pin_share_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic clkEn = 1'b1;
	logic iso = 1'b0;
	logic hold = 1'b0;
	portCfg_t c1 = '0;
	portCfg_t c2 = '0;
	portCfg_t c3 = '0;
	portCfg4_t c4 = '0;
	sfOut_t so = '0;
	padBus_t ext = '0;
	padBus_t pin;
	padBus_t pout;
	padBus_t poe;
	padBus_t prd;
	sfIn_t sfi;
	int errors = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #20 clk = ~clk;
	port_pin_sharing_and_isolation dut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
		.isolationModeInput(iso), .busHoldProtocolEnable(hold), .cfgOne(c1), .cfgTwo(c2),
		.cfgThree(c3), .cfgFour(c4), .sfOut(so), .padIn(pin), .padOut(pout), .padOe(poe),
		.portRead(prd), .sfIn(sfi));
	pad_board_model board (.padOut(pout), .padOe(poe), .boardDrive(ext), .padIn(pin));
	task end_sim;
		$display("errors=%0d cmp_count=%0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			errors++;
			end_sim();
		end
	end
	task chk(input logic [27:0] got, input logic [27:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			errors++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task step(input int n);
		repeat (n) @(negedge clk);
	endtask
	task rst(input logic s);
		reset_n = 1'b0;
		iso = s;
		step(16);
		reset_n = 1'b1;
		step(2);
		iso = ~s;
		step(2);
	endtask
	task t_port;
		c1 = '{8'ha5, 8'hff, 8'h00};
		c4 = '{4'h9, 4'hf, 4'hf};
		step(3);
		chk(pout.portOnePins, 8'ha5);
		chk(poe.portOnePins, 8'hff);
		chk(prd.portOnePins, 8'ha5);
		chk(poe.portFourPins, 4'hf);
		chk(pout.portFourPins, 4'h8);
	endtask
	task t_sf;
		c1 = '{8'h30, 8'hf0, 8'h0f};
		so.captureCompareOut = 4'h5;
		so.captureCompareOe = 4'h3;
		ext.portOnePins = 8'h5a;
		step(3);
		chk(poe.portOnePins, 8'hf3);
		chk(pout.portOnePins & 8'hf3, 8'h31);
		chk(sfi.captureCompareIn, 4'h9);
		chk({sfi.timerAClockIn, sfi.timerADirectionIn, sfi.timerBClockIn,
			sfi.timerBDirectionIn}, 4'hc);
		clkEn = 1'b0;
		c1.data = 8'h00;
		step(2);
		chk(pout.portOnePins[7:4], 4'h3);
		clkEn = 1'b1;
	endtask
	task t_other;
		c2 = '{8'h00, 8'h00, 8'hff};
		c3 = '{8'h00, 8'h00, 8'hff};
		so.serialTx = 1'b1;
		so.busRequestN = 1'b1;
		so.holdAcknowledgeN = 1'b1;
		so.clockOutput = 1'b1;
		so.chipSelectN = 6'h2a;
		ext.portTwoPins = 8'h36;
		ext.portThreePins = 8'h80;
		step(3);
		chk(poe.portTwoPins, 8'hc9);
		chk(pout.portTwoPins & 8'hc9, 8'hc9);
		chk(poe.portThreePins, 8'h3f);
		chk(pout.portThreePins[5:0], 6'h2a);
		chk(sfi.extIrq, 4'hb);
		chk({sfi.serialRx, sfi.holdRequestN}, 2'h3);
	endtask
	task t_hold;
		hold = 1'b1;
		c2 = '{8'hff, 8'hff, 8'h00};
		step(3);
		chk(poe.portTwoPins[6:5], 2'h2);
		chk(pout.portTwoPins[6], 1'b1);
		hold = 1'b0;
		step(4);
		chk(poe.portTwoPins[6:5], 2'h3);
	endtask
	task t_iso;
		rst(1'b1);
		chk(poe, 28'h0);
		rst(1'b0);
		chk(poe.portOnePins, 8'hf3);
	endtask
	initial
	begin
		rst(1'b0);
		t_port();
		t_sf();
		t_other();
		t_hold();
		t_iso();
		end_sim();
	end
endmodule
